/* logic/tbdo_top.sv */
// tick timer with periodic interrupt and buzzer square wave behind an apb slave
`timescale 1ns/100ps
module tbdo_top (
	input wire logic CLOCK, // 250 MHz system clock
	input wire logic RST, // synchronous reset, active high
	input wire logic HF_TICK, // one-cycle pulse per high_freq_clock period
	input wire logic LF_TICK, // one-cycle pulse per low_freq_clock period
	input wire tbdo_pkg::tbdo_mode_t MODE, // operating mode of the chip
	input wire logic PSEL, // apb select
	input wire logic PENABLE, // apb access phase
	input wire logic PWRITE, // apb direction, high for write
	input wire logic [tbdo_pkg::ADDR_W-1:0] PADDR, // apb byte address
	input wire logic [tbdo_pkg::DATA_W-1:0] PWDATA, // apb write data
	input wire logic [3:0] PSTRB, // apb byte strobes
	output logic [tbdo_pkg::DATA_W-1:0] PRDATA, // apb read data
	output logic PREADY, // apb ready
	output logic PSLVERR, // apb error on unmapped address
	output logic TICK_REQ, // tick_interrupt_request, one-cycle pulse
	output logic IRQ, // level interrupt, unmasked status pending
	output logic BUZZER_N // buzzer_output_pin, active low
);

	// bundled bus request
	tbdo_pkg::tbdo_apb_req_t req;

	// architectural state
	tbdo_pkg::tbdo_ctrl_t ctrl; // time_base_control
	logic [7:0] status; // sticky events
	logic [7:0] mask; // event mask

	// divider chains
	logic [tbdo_pkg::HF_DIV_W-1:0] hf_count; // full-speed chain
	logic [tbdo_pkg::LF_DIV_W-1:0] lf_count; // low-speed chain

	// tap selection
	logic use_lf; // low-frequency chain in use
	logic [4:0] tick_bit; // stage index of the tick tap
	logic [4:0] buz_bit; // stage index of the buzzer tap
	logic [tbdo_pkg::HF_DIV_W-1:0] sel_count; // chain feeding both taps
	logic sel_step; // step pulse of that chain
	logic tick_fall; // selected tick tap falls this cycle
	logic buz_level; // selected buzzer tap level

	// bus decode
	logic setup; // apb setup cycle seen by the slave
	logic access; // apb access completes this edge
	logic hit_ctrl; // address decodes to control
	logic hit_stat; // address decodes to status
	logic hit_mask; // address decodes to mask
	logic hit_view; // address decodes to divider view
	logic mapped; // any register hit
	logic lane0; // low byte strobe present

	// register write strobes
	logic wr_ctrl; // control write this edge
	logic wr_stat; // status clear this edge
	logic wr_mask; // mask write this edge

	// next values
	logic [7:0] next_status; // status after set and clear
	logic [tbdo_pkg::DATA_W-1:0] next_rdata; // read data for the access phase

	// does the byte address match one register word
	function automatic logic addr_is(
		input logic [tbdo_pkg::ADDR_W-1:0] addr,
		input logic [tbdo_pkg::ADDR_W-1:0] reg_addr
	);
		begin
			addr_is = (addr == reg_addr);
		end
	endfunction : addr_is

	// does stage idx of the chain fall on this step, all lower stages at one
	function automatic logic stage_falls(
		input logic [tbdo_pkg::HF_DIV_W-1:0] count,
		input logic [4:0] idx,
		input logic step
	);
		logic [tbdo_pkg::HF_DIV_W-1:0] m;
		begin
			m = {{(tbdo_pkg::HF_DIV_W-1){1'b0}}, 1'b1} << idx;
			m = m | (m - {{(tbdo_pkg::HF_DIV_W-1){1'b0}}, 1'b1});
			stage_falls = step && ((count & m) == m);
		end
	endfunction : stage_falls

	// pack the bus pins into one request
	assign req = '{sel: PSEL, enable: PENABLE, write: PWRITE, addr: PADDR, wdata: PWDATA};

	// full-speed divider, counts high_freq_clock periods
	tbdo_divider #(
		.WIDTH(tbdo_pkg::HF_DIV_W)
	) u_hf_div (
		.clock(CLOCK),
		.rst(RST),
		.step(HF_TICK),
		.count(hf_count)
	);

	// low-speed divider, counts low_freq_clock periods
	tbdo_divider #(
		.WIDTH(tbdo_pkg::LF_DIV_W)
	) u_lf_div (
		.clock(CLOCK),
		.rst(RST),
		.step(LF_TICK),
		.count(lf_count)
	);

	// chain choice: low-speed modes have no full-speed clock to divide
	always_comb begin
		use_lf = ctrl.prescaler_source_select;
		if (MODE == tbdo_pkg::MODE_LOW_RUN || MODE == tbdo_pkg::MODE_LOW_HALT) begin
			use_lf = 1'b1;
		end
	end

	// tap decode, stage k divides its source by 2^(k+1)
	always_comb begin
		if (use_lf) begin
			// only codes 000 and 001 are meaningful in low modes, others still tap the lf chain
			tick_bit = tbdo_pkg::LF_TICK_EXP[ctrl.tick_rate_select] - 5'h01;
			buz_bit = tbdo_pkg::LF_BUZ_EXP[ctrl.buzzer_rate_select] - 5'h01;
			sel_count = {{(tbdo_pkg::HF_DIV_W-tbdo_pkg::LF_DIV_W){1'b0}}, lf_count};
			sel_step = LF_TICK;
		end else begin
			// full-speed source in run or halt mode
			tick_bit = tbdo_pkg::HF_TICK_EXP[ctrl.tick_rate_select] - 5'h01;
			buz_bit = tbdo_pkg::HF_BUZ_EXP[ctrl.buzzer_rate_select] - 5'h01;
			sel_count = hf_count;
			sel_step = HF_TICK;
		end
	end

	// falling edge found from the carry, so a rate change never fakes an edge
	assign tick_fall = stage_falls(sel_count, tick_bit, sel_step);

	// buzzer tap is a plain divider stage, exactly half high and half low
	assign buz_level = sel_count[buz_bit];

	// bus phase decode
	assign setup = req.sel && !req.enable;
	assign access = req.sel && req.enable && PREADY;
	assign lane0 = PSTRB[0];

	// address decode, used for both reads and writes
	always_comb begin
		hit_ctrl = 1'b0;
		hit_stat = 1'b0;
		hit_mask = 1'b0;
		hit_view = 1'b0;
		if (addr_is(req.addr, tbdo_pkg::CTRL_ADDR)) begin
			hit_ctrl = 1'b1;
		end else if (addr_is(req.addr, tbdo_pkg::STAT_ADDR)) begin
			hit_stat = 1'b1;
		end else if (addr_is(req.addr, tbdo_pkg::MASK_ADDR)) begin
			hit_mask = 1'b1;
		end else if (addr_is(req.addr, tbdo_pkg::VIEW_ADDR)) begin
			hit_view = 1'b1;
		end
	end
	assign mapped = hit_ctrl || hit_stat || hit_mask || hit_view;

	// writes take effect only at the completing edge and need the low lane
	assign wr_ctrl = access && req.write && hit_ctrl && lane0;
	assign wr_stat = access && req.write && hit_stat && lane0;
	assign wr_mask = access && req.write && hit_mask && lane0;

	// read mux, upper bits read as zero
	always_comb begin
		next_rdata = '0;
		if (hit_ctrl) begin
			next_rdata[7:0] = ctrl;
		end else if (hit_stat) begin
			next_rdata[7:0] = status;
		end else if (hit_mask) begin
			next_rdata[7:0] = mask;
		end else if (hit_view) begin
			// live tap levels and chain choice, handy for software polling
			next_rdata[0] = sel_count[tick_bit];
			next_rdata[1] = buz_level;
			next_rdata[2] = use_lf;
		end
	end

	// ready rises for one cycle in the access phase, one wait-free answer
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			PREADY <= 1'b0;
		end else begin
			PREADY <= setup;
		end
	end

	// read data and error captured in the setup cycle, held through access
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			PRDATA <= '0;
			PSLVERR <= 1'b0;
		end else if (setup) begin
			PRDATA <= req.write ? '0 : next_rdata;
			PSLVERR <= !mapped;
		end else if (access) begin
			// drop data after the transfer so stale values do not linger
			PRDATA <= '0;
			PSLVERR <= 1'b0;
		end
	end

	// control register; rate fields are trusted to change only while disabled
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			ctrl <= tbdo_pkg::CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl <= req.wdata[7:0];
		end
	end

	// mask register, same layout as status
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			mask <= tbdo_pkg::MASK_RESET;
		end else if (wr_mask) begin
			mask <= req.wdata[7:0];
		end
	end

	// status: new event beats a clear written in the same cycle
	always_comb begin
		next_status = status;
		if (wr_stat) begin
			next_status = status & ~req.wdata[7:0];
		end
		if (ctrl.tick_enable && tick_fall) begin
			next_status[tbdo_pkg::TICK_EVT_POS] = 1'b1;
		end
	end

	// sticky status storage
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			status <= tbdo_pkg::STAT_RESET;
		end else begin
			status <= next_status;
		end
	end

	// request pulse on every tap fall while enabled, chain never restarted
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			TICK_REQ <= 1'b0;
		end else begin
			TICK_REQ <= ctrl.tick_enable && tick_fall;
		end
	end

	// level interrupt lags status by one cycle, traded for a clean flop output
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			IRQ <= 1'b0;
		end else begin
			IRQ <= |(status & mask);
		end
	end

	// buzzer pin: inverted tap when on, parked high when off
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			BUZZER_N <= 1'b1;
		end else if (ctrl.buzzer_output_enable) begin
			BUZZER_N <= ~buz_level;
		end else begin
			BUZZER_N <= 1'b1;
		end
	end

endmodule : tbdo_top

/* logic/tbdo_pkg.sv */
// package with register map, field layout and divider tap tables of the tick timer block
package tbdo_pkg;

	// apb byte address width in bits
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;

	// register indices, byte address is four times the index
	localparam logic [7:0] CTRL_IDX = 8'h36; // time_base_control
	localparam logic [7:0] STAT_IDX = 8'h37; // event status, write one to clear
	localparam logic [7:0] MASK_IDX = 8'h38; // event mask
	localparam logic [7:0] VIEW_IDX = 8'h39; // live divider view, read only
	localparam logic [ADDR_W-1:0] CTRL_ADDR = {2'h0, CTRL_IDX, 2'h0};
	localparam logic [ADDR_W-1:0] STAT_ADDR = {2'h0, STAT_IDX, 2'h0};
	localparam logic [ADDR_W-1:0] MASK_ADDR = {2'h0, MASK_IDX, 2'h0};
	localparam logic [ADDR_W-1:0] VIEW_ADDR = {2'h0, VIEW_IDX, 2'h0};

	// field positions of time_base_control
	localparam int BUZ_EN_POS = 7;
	localparam int BUZ_RATE_POS = 5;
	localparam int PRE_SRC_POS = 4;
	localparam int TICK_EN_POS = 3;
	localparam int TICK_RATE_POS = 0;

	// values after reset
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] STAT_RESET = 8'h00;
	localparam logic [7:0] MASK_RESET = 8'h00;

	// status and mask bit of the tick event
	localparam int TICK_EVT_POS = 0;

	// divider chain lengths
	localparam int HF_DIV_W = 23;
	localparam int LF_DIV_W = 15;

	// divide ratios as powers of two, indexed by the rate code
	localparam logic [4:0] HF_TICK_EXP [8] = '{5'h17, 5'h15, 5'h10, 5'h0E,
		5'h0D, 5'h0C, 5'h0B, 5'h09};
	localparam logic [4:0] LF_TICK_EXP [8] = '{5'h0F, 5'h0D, 5'h08, 5'h06,
		5'h05, 5'h04, 5'h03, 5'h01};
	localparam logic [4:0] HF_BUZ_EXP [4] = '{5'h0D, 5'h0C, 5'h0B, 5'h0A};
	localparam logic [4:0] LF_BUZ_EXP [4] = '{5'h05, 5'h04, 5'h03, 5'h02};

	// operating modes of the surrounding chip
	typedef enum logic [1:0] {
		MODE_FULL_RUN,
		MODE_FULL_HALT,
		MODE_LOW_RUN,
		MODE_LOW_HALT
	} tbdo_mode_t;

	// time_base_control layout
	typedef struct packed {
		logic buzzer_output_enable;
		logic [1:0] buzzer_rate_select;
		logic prescaler_source_select;
		logic tick_enable;
		logic [2:0] tick_rate_select;
	} tbdo_ctrl_t;

	// apb request as seen by the slave
	typedef struct packed {
		logic sel;
		logic enable;
		logic write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} tbdo_apb_req_t;

endpackage : tbdo_pkg

/* logic/tbdo_divider.sv */
// free-running binary divider chain advanced by a one-cycle step pulse
`timescale 1ns/100ps
module tbdo_divider #(
	parameter int WIDTH = 8 // chain length
) (
	input wire logic clock, // system clock
	input wire logic rst, // synchronous reset, active high
	input wire logic step, // one-cycle enable, one source clock period
	output logic [WIDTH-1:0] count // divider stages, bit k is source over 2^(k+1)
);

	// only hardware reset clears the chain, software has no way to do so
	always_ff @(posedge clock) begin
		if (rst) begin
			count <= '0;
		end else if (step) begin
			count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end

endmodule : tbdo_divider

/* tb/tbdo_asserts.sv */
// checker of bus timing, tick pulses and buzzer causes of the tick timer
`timescale 1ns/100ps
module tbdo_asserts (
	input wire logic CLOCK, // system clock
	input wire logic RST, // sync reset
	input wire logic HF_TICK, // hf step
	input wire logic LF_TICK, // lf step
	input wire logic PSEL, // select
	input wire logic PENABLE, // access phase
	input wire logic PWRITE, // direction
	input wire logic [tbdo_pkg::DATA_W-1:0] PRDATA, // read data
	input wire logic PREADY, // ready
	input wire logic PSLVERR, // error
	input wire logic TICK_REQ, // tick pulse
	input wire logic IRQ, // level interrupt
	input wire logic BUZZER_N // buzzer pin
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (RST);
	wire logic wr = PSEL && PENABLE && PWRITE; // write in access
	wire logic act = HF_TICK || LF_TICK || wr; // steps or a write, every cause apart from MODE that may move the pin
	ready_after_setup_a: assert property (PSEL && !PENABLE |=> PREADY)
		else $error("no ready after setup");
	ready_single_a: assert property (PREADY |=> !PREADY)
		else $error("ready held too long");
	err_with_ready_a: assert property (PSLVERR |-> PREADY)
		else $error("error without ready");
	tick_single_a: assert property (TICK_REQ |=> !TICK_REQ)
		else $error("tick pulse too long");
	tick_cause_a: assert property (TICK_REQ |-> $past(HF_TICK || LF_TICK))
		else $error("tick without step");
	irq_rise_a: assert property ($rose(IRQ) |-> $past(TICK_REQ) || $past(wr, 2))
		else $error("irq rose without cause");
	irq_fall_a: assert property ($fell(IRQ) |-> $past(wr, 2))
		else $error("irq fell without write");
	buzzer_cause_a: assert property ($changed(BUZZER_N) |-> $past(act) || $past(act, 2))
		else $error("buzzer moved without cause");
endmodule : tbdo_asserts
bind tbdo_top tbdo_asserts chk (.CLOCK, .RST, .HF_TICK, .LF_TICK, .PSEL, .PENABLE, .PWRITE,
	.PRDATA, .PREADY, .PSLVERR, .TICK_REQ, .IRQ, .BUZZER_N);

/* tb/tbdo_partner.sv */
// clock generator stand-in giving source period pulses
`timescale 1ns/100ps
module tbdo_partner (
	input wire logic clock, // system clock
	input wire logic rst, // sync reset
	input wire logic [1:0] gap, // cycles between pulses minus one
	output logic hf_tick, // hf period pulse
	output logic lf_tick // lf period pulse
);
	logic [1:0] cnt; // phase counter
	// lf lags hf when gap is 2 or 3; only gap 3 leaves the two idle cycles in a row that pin checks need
	always_ff @(posedge clock) begin
		cnt <= (rst || cnt >= gap) ? 2'h0 : cnt + 2'h1;
		hf_tick <= !rst && cnt == 2'h0;
		lf_tick <= !rst && cnt == (gap >> 1);
	end
endmodule : tbdo_partner

/* tb/tbdo_bench.sv */
// self-checking bench with a reference model of the tick timer
`timescale 1ns/100ps
module tbdo_bench;
	logic CLOCK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0; // bus and reset
	logic HF_TICK, LF_TICK, PREADY, PSLVERR, TICK_REQ, IRQ, BUZZER_N; // source pulses and design outputs
	logic [1:0] gap = 2'h0; // pulse spacing
	logic [3:0] PSTRB = 4'hF; // byte strobes
	logic [11:0] PADDR = 12'h000; // byte address
	logic [31:0] PWDATA = 32'h00000000, PRDATA; // data
	tbdo_pkg::tbdo_mode_t MODE = tbdo_pkg::MODE_FULL_RUN; // chip mode
	int mismatches = 0, checked = 0, seed = 32'h6159, hf, lf; // counts and model chains
	logic [7:0] ctl, st, mk; // model registers
	logic e_tick, e_irq, e_buz, buz_ok, pstp; // model outputs
	// {mode, source, code}, kept small so the run stays short
	localparam logic [5:0] CASES [15] = '{6'h04, 6'h05, 6'h06, 6'h07, 6'h15, 6'h09, 6'h0A,
		6'h0B, 6'h0C, 6'h0D, 6'h0E, 6'h0F, 6'h1A, 6'h20, 6'h39};
	initial forever #2 CLOCK = ~CLOCK;
	tbdo_top DUT (.CLOCK, .RST, .HF_TICK, .LF_TICK, .MODE, .PSEL, .PENABLE, .PWRITE, .PADDR,
		.PWDATA, .PSTRB, .PRDATA, .PREADY, .PSLVERR, .TICK_REQ, .IRQ, .BUZZER_N);
	tbdo_partner src (.clock(CLOCK), .rst(RST), .gap, .hf_tick(HF_TICK), .lf_tick(LF_TICK));
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR at %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task close_out;
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : close_out
	// one bus transfer; read data is judged by the model at the ready edge
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge CLOCK);
		PSEL <= 1'b1;
		PWRITE <= wr;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLOCK);
		PENABLE <= 1'b1;
		n = 0;
		do begin
			@(posedge CLOCK);
			n++;
		end while (PREADY !== 1'b1 && n < 20);
		if (n >= 20) begin
			mismatches++;
			close_out;
		end
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask : apb
	// model: old register values decide this edge, writes land after
	always @(posedge CLOCK) begin
		logic lfs, ev;
		int c, te, be;
		lfs = ctl[4] | MODE[1];
		c = lfs ? lf : hf;
		te = lfs ? tbdo_pkg::LF_TICK_EXP[ctl[2:0]] : tbdo_pkg::HF_TICK_EXP[ctl[2:0]];
		be = lfs ? tbdo_pkg::LF_BUZ_EXP[ctl[6:5]] : tbdo_pkg::HF_BUZ_EXP[ctl[6:5]];
		ev = ctl[3] && (lfs ? LF_TICK : HF_TICK) && (c + 1) % (1 << te) == 0;
		if (RST) begin
			{hf, lf, ctl, st, mk, e_tick, e_irq, e_buz, pstp} = '0;
			e_buz = 1'b1;
		end else begin
			// flop outputs see the registers as they stood before this edge's write
			e_irq = |(st & mk);
			e_buz = ctl[7] ? ~c[be-1] : 1'b1;
			if (PSEL && PENABLE && PREADY === 1'b1) begin
				if (!PWRITE) case (PADDR)
					tbdo_pkg::CTRL_ADDR: chk(PRDATA, ctl);
					tbdo_pkg::STAT_ADDR: chk(PRDATA, st);
					tbdo_pkg::MASK_ADDR: chk(PRDATA, mk);
					tbdo_pkg::VIEW_ADDR: ;
					default: chk(PSLVERR, 1);
				endcase
				else if (PSTRB[0]) case (PADDR)
					tbdo_pkg::CTRL_ADDR: ctl = PWDATA[7:0];
					tbdo_pkg::STAT_ADDR: st = st & ~PWDATA[7:0];
					tbdo_pkg::MASK_ADDR: mk = PWDATA[7:0];
					default: ;
				endcase
			end
			e_tick = ev;
			st[0] = st[0] | ev;
			buz_ok = !(HF_TICK || LF_TICK) && !pstp;
			pstp = HF_TICK || LF_TICK;
			hf += HF_TICK;
			lf += LF_TICK;
		end
	end
	always @(negedge CLOCK) if (!RST) begin
		chk(TICK_REQ, e_tick);
		chk(IRQ, e_irq);
		if (buz_ok) chk(BUZZER_N, e_buz);
	end
	initial begin
		int n;
		repeat (10) @(posedge CLOCK);
		RST <= 1'b0;
		apb(0, tbdo_pkg::CTRL_ADDR, 0);
		apb(0, tbdo_pkg::STAT_ADDR, 0);
		apb(0, 12'h000, 0);
		PSTRB <= 4'h0;
		apb(1, tbdo_pkg::CTRL_ADDR, 32'h00000077);
		PSTRB <= 4'hF;
		repeat (4) begin
			apb(1, tbdo_pkg::CTRL_ADDR, $random(seed) & 32'h00000077);
			apb(0, tbdo_pkg::CTRL_ADDR, 0);
		end
		for (int i = 0; i < 15; i++) begin
			MODE <= tbdo_pkg::tbdo_mode_t'(CASES[i][5:4]);
			apb(1, tbdo_pkg::MASK_ADDR, $random(seed) & 32'h000000FF);
			apb(1, tbdo_pkg::CTRL_ADDR, {27'h0, CASES[i][3], 1'b1, CASES[i][2:0]});
			n = 0;
			while (TICK_REQ !== 1'b1 && n < 40000) begin
				@(negedge CLOCK);
				n++;
			end
			if (n >= 40000) begin
				mismatches++;
				close_out;
			end
			apb(0, tbdo_pkg::STAT_ADDR, 0);
			apb(1, tbdo_pkg::STAT_ADDR, 32'h00000001);
			apb(1, tbdo_pkg::CTRL_ADDR, {27'h0, CASES[i][3], 1'b0, CASES[i][2:0]});
		end
		MODE <= tbdo_pkg::MODE_FULL_RUN;
		gap <= 2'h2;
		for (int j = 0; j < 8; j++) begin
			apb(1, tbdo_pkg::CTRL_ADDR, {24'h0, 1'b0, j[1:0], j[2], 4'h0});
			apb(1, tbdo_pkg::CTRL_ADDR, {24'h0, 1'b1, j[1:0], j[2], 4'h0});
			repeat (100) @(posedge CLOCK);
			apb(1, tbdo_pkg::CTRL_ADDR, {24'h0, 1'b0, j[1:0], j[2], 4'h0});
		end
		close_out;
	end
endmodule : tbdo_bench
